// ---- verilog/bpmc_pkg.sv ----
// Function
// [R1] Enable needs one pin high and VCC good.
// [R2] Per-mode lockout on battery, output and VCC.
// [R3] Serial interface enabled when either pin high.
// [R4] Both pins low: shutdown, registers reset, interface off.
// [R5] Pin high, bits clear: standby, registers kept.
// [R6] Shutdown and standby keep power path open.
// [R7] Boost enabled by pin AND bit.
// [R8] Select 01b charger, 10b health test, 00b neither.
// [R9] Boost only: boost below wake, standby above 106%.
// [R10] Boost plus function: function above 106%, boost below wake.
// [R11] Boost disabled: pure charger or health test.
// [R12] Several functions: monitor output, auto boost on drop.
// [R13] Spread spectrum dithers switching clock within 7 percent.
// [R14] Wake threshold comes from programmable register field.
// [R15] Charger also needs output below overvoltage limit.
// [R16] Between wake and standby thresholds hold mode.
// [R17] Comparator results synchronized before mode selection.
package bpmc_pkg;

	// Charger/health select field encodings.
	localparam logic [1:0] SEL_NONE    = 2'h0;
	localparam logic [1:0] SEL_CHARGER = 2'h1;
	localparam logic [1:0] SEL_HEALTH  = 2'h2;

	// Register reset values applied while both pins are low.
	localparam logic       BOOST_BIT_RST   = 1'h0;
	localparam logic [1:0] SELECT_RST      = 2'h0;
	localparam logic       SPREAD_RST      = 1'h0;
	localparam logic [3:0] WAKE_THRESH_RST = 4'h0;
	localparam int         WAKE_W          = 4;

	// Switching clock: 200 MHz system clock, 400 kHz nominal.
	localparam int SYS_CLK_KHZ  = 200000;
	localparam int SW_FREQ_KHZ  = 400;
	localparam int SW_PERIOD    = SYS_CLK_KHZ / SW_FREQ_KHZ;
	// Dither of 7 percent of the period, rounded down to stay inside the band.
	localparam int DITHER_PCT   = 7;
	localparam int DITHER_SPAN  = SW_PERIOD * DITHER_PCT / 100;
	localparam int CNT_W        = 10;
	localparam int LFSR_W       = 8;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 8'ha5;
	localparam logic [LFSR_W-1:0] LFSR_TAPS = 8'hb8;

	// Number of comparator inputs passed through the synchroniser.
	localparam int SYNC_N = 7;

	// Operating modes, one-hot.
	typedef enum logic [4:0] {
		MODE_SHUTDOWN = 5'h01,
		MODE_STANDBY  = 5'h02,
		MODE_BOOST    = 5'h04,
		MODE_CHARGER  = 5'h08,
		MODE_HEALTH   = 5'h10
	} bpmc_mode_t;

endpackage

// ---- verilog/bpmc_dither.sv ----
`timescale 1ns/100ps
// Switching clock generator with optional spread spectrum.
module bpmc_dither
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rst,
	// Control.
	input  wire logic run,
	input  wire logic spread_enable,
	// Switching tick, one cycle per switching period.
	output logic      sw_tick
);

	// Period counter and pseudo-random generator.
	logic [bpmc_pkg::CNT_W-1:0]  count_q;
	logic [bpmc_pkg::CNT_W-1:0]  limit_q;
	logic [bpmc_pkg::LFSR_W-1:0] lfsr_q;
	logic [bpmc_pkg::CNT_W-1:0]  offset;
	logic [bpmc_pkg::CNT_W-1:0]  next_limit;

	// Offset folded into the band 0..2*span so the period stays within plus or minus span.
	assign offset = bpmc_pkg::CNT_W'(lfsr_q % (2 * bpmc_pkg::DITHER_SPAN + 1));
	always_comb
	begin
		if (spread_enable)
			next_limit = bpmc_pkg::CNT_W'(bpmc_pkg::SW_PERIOD - bpmc_pkg::DITHER_SPAN - 1) + offset; // [R13]
		else
			next_limit = bpmc_pkg::CNT_W'(bpmc_pkg::SW_PERIOD - 1);
	end

	// The LFSR advances once per period, so each period gets a fresh length.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			count_q <= '0;
			limit_q <= bpmc_pkg::CNT_W'(bpmc_pkg::SW_PERIOD - 1);
			lfsr_q  <= bpmc_pkg::LFSR_SEED;
			sw_tick <= 1'b0;
		end
		else if (!run)
		begin
			// Held quiet while no power stage switches.
			count_q <= '0;
			sw_tick <= 1'b0;
		end
		else if (count_q >= limit_q)
		begin
			count_q <= '0;
			sw_tick <= 1'b1;
			limit_q <= next_limit;
			lfsr_q  <= (lfsr_q >> 1) ^ (lfsr_q[0] ? bpmc_pkg::LFSR_TAPS : '0);
		end
		else
		begin
			count_q <= count_q + 1'b1;
			sw_tick <= 1'b0;
		end
	end

endmodule

// ---- verilog/bpmc_mode_ctrl.sv ----
`timescale 1ns/100ps
// Mode control of a backup power converter.
module bpmc_mode_ctrl
(
	// Clock and reset.
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	// Enable pins from the microcontroller.
	input  wire logic                        boost_enable_pin,
	input  wire logic                        charge_enable_pin,
	// Register writes from the serial interface.
	input  wire logic                        reg_write,
	input  wire logic                        boost_enable_bit_wr,
	input  wire logic [1:0]                  charge_health_select_wr,
	input  wire logic                        spread_enable_wr,
	input  wire logic [bpmc_pkg::WAKE_W-1:0] boost_wake_threshold_wr,
	// Raw comparator results.
	input  wire logic                        vcc_good,
	input  wire logic                        battery_above_lockout,
	input  wire logic                        output_above_lockout,
	input  wire logic                        output_below_wake,
	input  wire logic                        output_above_standby,
	input  wire logic                        output_below_overvoltage,
	input  wire logic                        wake_match,
	// Register contents.
	output logic                             boost_enable_bit,
	output logic [1:0]                       charge_health_select,
	output logic                             spread_enable,
	output logic [bpmc_pkg::WAKE_W-1:0]      boost_wake_threshold,
	// Mode and power stage controls.
	output logic                             serial_enable,
	output logic                             device_enabled,
	output logic [4:0]                       mode,
	output logic                             power_path_closed,
	output logic                             boost_run,
	output logic                             charger_run,
	output logic                             health_run,
	output logic                             sw_tick
);

	// Synchroniser stages for all comparator inputs.
	logic [bpmc_pkg::SYNC_N-1:0] sync1_q;
	logic [bpmc_pkg::SYNC_N-1:0] sync2_q;
	logic [bpmc_pkg::SYNC_N-1:0] raw;

	// Synchronised comparator flags.
	logic vcc_ok;
	logic bat_ok;
	logic out_ok;
	logic below_wake;
	logic above_standby;
	logic below_ovp;

	// Derived enables.
	logic any_pin;
	logic boost_en;
	logic charger_en;
	logic health_en;
	logic func_en;

	// Mode register.
	bpmc_pkg::bpmc_mode_t mode_q;
	bpmc_pkg::bpmc_mode_t mode_d;

	assign raw = {wake_match, output_below_overvoltage, output_above_standby,
		output_below_wake, output_above_lockout, battery_above_lockout, vcc_good};

	// Two-flop synchroniser; only the second stage feeds the mode logic.
	// The comparators switch on analog edges with no relation to the clock,
	// so reading the first stage would risk a metastable value in the mode logic.
	// The cost is two cycles of extra latency before a rail change is seen,
	// which is far below the time the rail takes to move between thresholds.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= raw; // [R17]
			sync2_q <= sync1_q; // [R17]
		end
	end

	assign vcc_ok        = sync2_q[0];
	assign bat_ok        = sync2_q[1];
	assign out_ok        = sync2_q[2];
	// Wake comparator outcome is qualified by the programmed threshold match.
	assign below_wake    = sync2_q[3] & sync2_q[6]; // [R14]
	assign above_standby = sync2_q[4];
	assign below_ovp     = sync2_q[5];

	// Pin-level enable; either pin wakes the device and its serial port.
	assign any_pin        = boost_enable_pin | charge_enable_pin;
	assign serial_enable  = any_pin; // [R3]
	assign device_enabled = any_pin & vcc_ok; // [R1]

	// Function enables follow the AND of pins and bits.
	assign boost_en   = boost_enable_pin & boost_enable_bit; // [R7]
	assign charger_en = charge_enable_pin & (charge_health_select == bpmc_pkg::SEL_CHARGER) & below_ovp; // [R8] [R15]
	assign health_en  = charge_enable_pin & (charge_health_select == bpmc_pkg::SEL_HEALTH); // [R8]
	assign func_en    = charger_en | health_en;

	// Registers return to defaults while both pins are low; contents kept in standby.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			boost_enable_bit     <= bpmc_pkg::BOOST_BIT_RST;
			charge_health_select <= bpmc_pkg::SELECT_RST;
			spread_enable        <= bpmc_pkg::SPREAD_RST;
			boost_wake_threshold <= bpmc_pkg::WAKE_THRESH_RST;
		end
		else if (!any_pin)
		begin
			boost_enable_bit     <= bpmc_pkg::BOOST_BIT_RST; // [R4]
			charge_health_select <= bpmc_pkg::SELECT_RST; // [R4]
			spread_enable        <= bpmc_pkg::SPREAD_RST; // [R4]
			boost_wake_threshold <= bpmc_pkg::WAKE_THRESH_RST; // [R4]
		end
		else if (reg_write)
		begin
			// Writes only land while the serial interface is enabled.
			boost_enable_bit     <= boost_enable_bit_wr;
			charge_health_select <= charge_health_select_wr;
			spread_enable        <= spread_enable_wr;
			boost_wake_threshold <= boost_wake_threshold_wr; // [R14]
		end
	end

	// Mode selection from pins, bits and synchronised comparisons.
	// Pins act directly, so shutdown follows a pin change on the next edge.
	// Rail comparisons act only through the synchroniser.
	// Boost wins over any other enabled function while the rail sags, since
	// the load must be held up before the battery is charged or tested.
	// Inside the hold band boost, standby and a still-enabled function are kept, which gives the hysteresis that
	// stops the converter from toggling around a single threshold.
	always_comb
	begin
		mode_d = mode_q;
		if (!device_enabled)
			mode_d = bpmc_pkg::MODE_SHUTDOWN; // [R1] [R4]
		else if (!boost_en && !func_en)
			mode_d = bpmc_pkg::MODE_STANDBY; // [R5]
		else if (!boost_en)
			mode_d = charger_en ? bpmc_pkg::MODE_CHARGER : bpmc_pkg::MODE_HEALTH; // [R11]
		else if (below_wake)
			mode_d = bpmc_pkg::MODE_BOOST; // [R9] [R10] [R12]
		else if (above_standby)
		begin
			if (charger_en)
				mode_d = bpmc_pkg::MODE_CHARGER; // [R10]
			else if (health_en)
				mode_d = bpmc_pkg::MODE_HEALTH; // [R10]
			else
				mode_d = bpmc_pkg::MODE_STANDBY; // [R9]
		end
		else if (mode_q == bpmc_pkg::MODE_SHUTDOWN)
			mode_d = bpmc_pkg::MODE_STANDBY; // [R16]
		else if (mode_q == bpmc_pkg::MODE_CHARGER && !charger_en)
			mode_d = bpmc_pkg::MODE_STANDBY; // [R16]
		else if (mode_q == bpmc_pkg::MODE_HEALTH && !health_en)
			mode_d = bpmc_pkg::MODE_STANDBY; // [R16]
		else
			mode_d = mode_q; // [R16]
	end

	// Mode register.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			mode_q <= bpmc_pkg::MODE_SHUTDOWN;
		else
			mode_q <= mode_d;
	end

	assign mode = mode_q;

	// Power stage enables, gated by the per-mode lockout of battery, output and supply.
	// The battery and output lockouts gate the stage but do not change the mode, so a short
	// dip of either resumes the same function without a pass through standby; a VCC dip forces shutdown.
	// Standby and shutdown drive nothing, which keeps the battery disconnected.
	always_comb
	begin
		boost_run   = 1'b0;
		charger_run = 1'b0;
		health_run  = 1'b0;
		unique case (mode_q)
			bpmc_pkg::MODE_BOOST:   boost_run   = bat_ok & vcc_ok; // [R2]
			bpmc_pkg::MODE_CHARGER: charger_run = out_ok & vcc_ok; // [R2]
			bpmc_pkg::MODE_HEALTH:  health_run  = out_ok & vcc_ok; // [R2]
			bpmc_pkg::MODE_STANDBY,
			bpmc_pkg::MODE_SHUTDOWN: ;
			default: ;
		endcase
	end

	// Battery stays disconnected unless a power function runs.
	assign power_path_closed = boost_run | charger_run | health_run; // [R6]

	// Switching clock with optional dither.
	bpmc_dither u_dither
	(
		.clk_sys       (clk_sys),
		.rst           (rst),
		.run           (power_path_closed),
		.spread_enable (spread_enable),
		.sw_tick       (sw_tick)
	);

endmodule

// ---- verification/bpmc_vout_model.sv ----
`timescale 1ns/100ps
// Output rail seen through its comparators: 0 sagging, 1 in band, 2 high.
module bpmc_vout_model
(
	// Rail level chosen by the bench.
	input  wire logic [1:0] zone,
	// Comparator results.
	output logic            output_below_wake,
	output logic            output_above_standby,
	output logic            wake_match
);
	// The two thresholds never trip together, which leaves a hold band.
	assign output_below_wake    = (zone == 2'h0);
	assign output_above_standby = (zone == 2'h2);
	assign wake_match           = (zone == 2'h0);
endmodule

// ---- verification/bpmc_monitor.sv ----
`timescale 1ns/100ps
// Port checks of the mode controller.
module bpmc_monitor
(
	// Clock and reset.
	input wire logic       clk_sys,
	input wire logic       rst,
	// Watched ports.
	input wire logic       boost_enable_pin,
	input wire logic       charge_enable_pin,
	input wire logic       boost_enable_bit,
	input wire logic [1:0] charge_health_select,
	input wire logic       serial_enable,
	input wire logic       device_enabled,
	input wire logic [4:0] mode,
	input wire logic       power_path_closed,
	input wire logic       sw_tick
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	serial_on_a: assert property (serial_enable == (boost_enable_pin | charge_enable_pin))
		else $error("serial enable wrong");
	enable_pin_a: assert property (device_enabled |-> boost_enable_pin | charge_enable_pin)
		else $error("enabled with pins low");
	shut_reset_a: assert property (!boost_enable_pin && !charge_enable_pin |=> !boost_enable_bit && charge_health_select == 2'h0)
		else $error("registers kept in shutdown");
	path_open_a: assert property (mode inside {5'h01, 5'h02} |-> !power_path_closed)
		else $error("power path closed");
	boost_gate_a: assert property (mode == 5'h04 |-> $past(boost_enable_pin) && $past(boost_enable_bit))
		else $error("boost without pin and bit");
	charger_gate_a: assert property (mode == 5'h08 |-> $past(charge_enable_pin) && $past(charge_health_select) == 2'h1)
		else $error("charger without select");
	mode_hot_a: assert property ($onehot(mode))
		else $error("mode not one-hot");
	tick_pulse_a: assert property (sw_tick |=> !sw_tick)
		else $error("tick too long");
	// Main scenarios.
	boost_c: cover property (mode == 5'h04);
	charger_c: cover property (mode == 5'h08);
	health_c: cover property (mode == 5'h10);
endmodule
bind bpmc_mode_ctrl bpmc_monitor mon (.clk_sys(clk_sys), .rst(rst), .boost_enable_pin(boost_enable_pin),
	.charge_enable_pin(charge_enable_pin), .boost_enable_bit(boost_enable_bit),
	.charge_health_select(charge_health_select), .serial_enable(serial_enable), .device_enabled(device_enabled),
	.mode(mode), .power_path_closed(power_path_closed), .sw_tick(sw_tick));

// ---- verification/tb_backup_power_mode_control.sv ----
`timescale 1ns/100ps
// Mode controller bench.
module tb_backup_power_mode_control;
	logic       clk_sys, rst, bp, cp, wr_q, bit_q, spr_q, vcc, bat, olk, ovp;
	logic [1:0] sel_q, zone;
	logic       bw, ab, wm, be_bit, sp, ser, den, ppc, brun, crun, hrun, tick;
	logic [1:0] sel;
	logic [3:0] wake;
	logic [4:0] mode;
	int         bad_count, comparisons, cycles, n;
	bpmc_vout_model vout (.zone(zone), .output_below_wake(bw), .output_above_standby(ab), .wake_match(wm));
	bpmc_mode_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .boost_enable_pin(bp), .charge_enable_pin(cp),
		.reg_write(wr_q), .boost_enable_bit_wr(bit_q), .charge_health_select_wr(sel_q), .spread_enable_wr(spr_q),
		.boost_wake_threshold_wr(4'h9), .vcc_good(vcc), .battery_above_lockout(bat), .output_above_lockout(olk),
		.output_below_wake(bw), .output_above_standby(ab), .output_below_overvoltage(ovp), .wake_match(wm),
		.boost_enable_bit(be_bit), .charge_health_select(sel), .spread_enable(sp), .boost_wake_threshold(wake),
		.serial_enable(ser), .device_enabled(den), .mode(mode), .power_path_closed(ppc), .boost_run(brun),
		.charger_run(crun), .health_run(hrun), .sw_tick(tick));
	// Clock at 200 MHz.
	initial
	begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Cut a hang short.
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end
	// Let n edges pass, then settle just after the last.
	task cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// One register write through the strobe.
	task wr(logic b, logic [1:0] s);
		wr_q = 1;
		bit_q = b;
		sel_q = s;
		spr_q = 1;
		cyc(1);
		wr_q = 0;
	endtask
	// Compare a result against its expected value.
	task chk(logic [4:0] got, logic [4:0] exp);
		comparisons++;
		if (got !== exp)
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			bad_count++;
	endtask
	// Verdict and end of run.
	task tally_and_finish();
		if (bad_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence.
	initial
	begin
		{rst, bp, cp, wr_q, bit_q, spr_q, sel_q} = '1;
		{bp, cp, wr_q, bit_q, spr_q, sel_q} = '0;
		{vcc, bat, olk, ovp, zone} = {4'hf, 2'h1};
		cyc(2);
		rst = 0;
		chk(mode, 5'h01);
		chk(ser, 0);
		bp = 1;
		cyc(4);
		chk(mode, 5'h02);
		chk(ser, 1);
		chk(ppc, 0);
		wr(1, 2'h0);
		chk(wake, 4'h9);
		zone = 0;
		cyc(5);
		chk(mode, 5'h04);
		chk(brun, 1);
		// A switching tick must come within 600 cycles, more than the longest dithered period.
		n = 0;
		while (!tick && n < 600)
		begin
			cyc(1);
			n++;
		end
		chk(tick, 1);
		bat = 0;
		cyc(4);
		chk(brun, 0);
		bat = 1;
		zone = 1;
		cyc(5);
		chk(mode, 5'h04);
		zone = 2;
		cyc(5);
		chk(mode, 5'h02);
		cp = 1;
		wr(1, 2'h1);
		cyc(5);
		chk(mode, 5'h08);
		chk(crun, 1);
		zone = 0;
		cyc(5);
		chk(mode, 5'h04);
		zone = 2;
		cyc(5);
		chk(mode, 5'h08);
		vcc = 0;
		cyc(4);
		chk(den, 0);
		vcc = 1;
		wr(0, 2'h2);
		cyc(5);
		chk(mode, 5'h10);
		zone = 0;
		cyc(5);
		chk(hrun, 1);
		wr(0, 2'h1);
		cyc(5);
		chk(mode, 5'h08);
		{bp, cp} = 2'h0;
		cyc(2);
		chk(mode, 5'h01);
		wr(1, 2'h1);
		cyc(1);
		chk({be_bit, sel, sp}, 5'h00);
		chk(ser, 0);
		tally_and_finish();
	end
endmodule
